// ---- design/bcs_defines.svh ----
// Purpose: timing counts, window positions and widths of the beta count sequencer
// Assumes: 200 MHz system clock
// Notes: minute counts and window minute numbers live here as macros; history indices are fixed in the sequencer
`ifndef BCS_DEFINES_SVH
`define BCS_DEFINES_SVH

// clock and minute timing
`define BCS_CLK_PERIOD_PS 64'd5000
`define BCS_MINUTE_S 64'd60
`define BCS_MINUTE_CYCLES ((`BCS_MINUTE_S * 64'd1000000000000) / `BCS_CLK_PERIOD_PS)
`define BCS_TICK_W 34

// data widths
`define BCS_CNT_W 20
`define BCS_SUM_W 22
`define BCS_RAW_W 24
`define BCS_HIST_DEPTH 12

// real-time window sequencing, in minutes since restart
`define BCS_ZERO_LOAD_MIN 8'd4
`define BCS_FIRST_RAW_MIN 8'd5
`define BCS_NORMAL_MIN 8'd12
`define BCS_TAPE_MIN_MAX 8'hFF

// hourly sequencing, in minutes of the hour
`define BCS_HOUR_MIN 7'd60
`define BCS_ZERO_FIRST 7'd2
`define BCS_ZERO_LAST 7'd5
`define BCS_SPAN_FIRST 7'd57
`define BCS_SPAN_LAST 7'd60
`define BCS_HOUR_DIV 8'd60

// daily average
`define BCS_DAY_HOURS 5'd24
`define BCS_DAY_DIV 8'd24

// real-time average periods in minutes
`define BCS_RT_P1 7'd1
`define BCS_RT_P5 7'd5
`define BCS_RT_P10 7'd10
`define BCS_RT_P15 7'd15
`define BCS_RT_P30 7'd30
`define BCS_RT_P60 7'd60

// correction factor fraction bits
`define BCS_CORR_FRAC 8

`endif

// ---- design/bcs_pkg.sv ----
// Purpose: types shared by the beta count sequencer
// Assumes: nothing
// Notes: encodings are free; decoding is in the sequencer
package bcs_pkg;

	// selectable real-time average period
	typedef enum logic [2:0] {
		RT_1MIN,
		RT_5MIN,
		RT_10MIN,
		RT_15MIN,
		RT_30MIN,
		RT_60MIN
	} bcs_rt_period_type;

	// tape advance handshake
	typedef enum logic [1:0] {
		ADV_IDLE,
		ADV_WAIT,
		ADV_MOVE
	} bcs_adv_state_type;

endpackage

// ---- design/bcs_divider.sv ----
// Purpose: serial signed-by-unsigned divider for the averaging stages
// Assumes: divisor is nonzero; a start while busy is ignored
// Notes: done pulses 33 cycles after the accepted start
`timescale 1ns/100ps
`default_nettype none

module bcs_divider (
	input wire logic i_clk_sys, // system clock
	input wire logic i_arst_n, // async reset, active low
	input wire logic i_start, // start pulse
	input wire logic signed [31:0] i_dividend, // signed dividend
	input wire logic [7:0] i_divisor, // unsigned divisor
	output logic o_busy, // division running
	output logic o_done, // quotient valid pulse
	output logic signed [31:0] o_quot // truncated quotient
);

	logic [31:0] mag;
	logic [8:0] rem;
	logic [7:0] den;
	logic [5:0] cnt;
	logic neg;
	logic [8:0] rem_sh;

	assign rem_sh = {rem[7:0], mag[31]};

	////////////////////////////////////////////////////////////////////////////////
	// restoring shift-subtract loop
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mag <= 32'h0;
			rem <= 9'h0;
			den <= 8'h0;
			cnt <= 6'h0;
			neg <= 1'b0;
			o_busy <= 1'b0;
		end else if (i_start && !o_busy) begin
			neg <= i_dividend[31];
			mag <= i_dividend[31] ? 32'(-i_dividend) : i_dividend;
			rem <= 9'h0;
			den <= i_divisor;
			cnt <= 6'h20;
			o_busy <= 1'b1;
		end else if (o_busy && cnt != 6'h0) begin
			if (rem_sh >= {1'b0, den}) begin
				rem <= rem_sh - {1'b0, den};
				mag <= {mag[30:0], 1'b1};
			end else begin
				rem <= rem_sh;
				mag <= {mag[30:0], 1'b0};
			end
			cnt <= cnt - 6'h1;
		end else if (o_busy) begin
			o_busy <= 1'b0;
		end
	end

	// result register and done pulse
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_done <= 1'b0;
			o_quot <= 32'h0;
		end else begin
			o_done <= o_busy && cnt == 6'h0;
			if (o_busy && cnt == 6'h0) begin
				o_quot <= (den == 8'h0) ? 32'h0 : (neg ? 32'(-mag) : mag);
			end
		end
	end

endmodule // bcs_divider

`default_nettype wire

// ---- design/bcs_sequencer.sv ----
// Purpose: minute sequencing, rolling windows, real-time, hourly and daily averages
// Assumes: beta pulses, clog and tape-busy arrive from pins; the rest is same-clock logic
// Notes: concentration math is reduced to window differences and correction products
`timescale 1ns/100ps
`default_nettype none
`include "bcs_defines.svh"

module bcs_sequencer #(
	parameter logic [`BCS_TICK_W-1:0] P_MINUTE_CYCLES = `BCS_TICK_W'(`BCS_MINUTE_CYCLES)
) (
	input wire logic i_clk_sys, // system clock
	input wire logic i_arst_n, // async reset, active low
	input wire logic i_beta_pulse, // detector pulse pin
	input wire logic i_tape_clog, // tape clog sense pin
	input wire logic i_tape_busy, // tape transport moving pin
	input wire logic i_advance_due, // periodic advance request pulse
	input wire bcs_pkg::bcs_rt_period_type i_rt_period, // real-time average period
	input wire logic [15:0] i_air_corr, // air density factor, Q8.8
	input wire logic [15:0] i_temp_corr, // temperature factor, Q8.8
	output logic o_tape_advance, // advance request to transport
	output logic o_pump_on, // vacuum pump enable
	output logic o_clog_alarm, // forced-advance alarm pulse
	output logic [`BCS_CNT_W-1:0] o_minute_total, // last minute beta total
	output logic [`BCS_CNT_W-1:0] o_final_window_average, // final window mean
	output logic o_raw_valid, // raw value pulse
	output logic o_raw_prelim, // raw value is preliminary
	output logic signed [`BCS_RAW_W-1:0] o_raw_conc, // raw corrected value
	output logic o_rt_valid, // real-time average pulse
	output logic signed [31:0] o_rt_avg, // real-time average, held
	output logic o_hour_valid, // hourly value pulse
	output logic signed [31:0] o_hour_conc, // hourly value
	output logic o_hour_split, // hour had a tape advance
	output logic o_hour_pd_alarm, // hour had a clog advance
	output logic o_day_valid, // daily average pulse
	output logic signed [31:0] o_day_avg // daily average
);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers, two flops per pin
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic [2:0] pin_in;
	logic beta_prev;
	logic clog_prev;
	logic busy_s;

	assign pin_in = {i_tape_busy, i_tape_clog, i_beta_pulse};
	assign busy_s = sync_b[2];

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
				if (!i_arst_n) begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
				end else begin
					sync_a[gi] <= pin_in[gi];
					sync_b[gi] <= sync_a[gi];
				end
			end
		end
	endgenerate

	// edge history of synchronised pins
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			beta_prev <= 1'b0;
			clog_prev <= 1'b0;
		end else begin
			beta_prev <= sync_b[0];
			clog_prev <= sync_b[1];
		end
	end

	logic beta_edge;
	logic clog_rise;
	assign beta_edge = sync_b[0] && !beta_prev;
	assign clog_rise = sync_b[1] && !clog_prev;

	////////////////////////////////////////////////////////////////////////////////
	// tape advance handshake and pump control
	bcs_pkg::bcs_adv_state_type adv_state;
	logic restart;
	logic clog_pending;

	assign restart = (adv_state == bcs_pkg::ADV_MOVE) && !busy_s;

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			adv_state <= bcs_pkg::ADV_IDLE;
			o_tape_advance <= 1'b0;
			o_clog_alarm <= 1'b0;
			o_pump_on <= 1'b1;
			clog_pending <= 1'b0;
		end else begin
			o_clog_alarm <= 1'b0;
			unique case (adv_state)
				bcs_pkg::ADV_IDLE: begin
					if (clog_rise || i_advance_due) begin
						adv_state <= bcs_pkg::ADV_WAIT;
						o_tape_advance <= 1'b1;
						o_clog_alarm <= clog_rise;
						clog_pending <= clog_rise;
					end
				end
				bcs_pkg::ADV_WAIT: begin
					if (busy_s) begin
						adv_state <= bcs_pkg::ADV_MOVE;
						o_tape_advance <= 1'b0;
						o_pump_on <= 1'b0;
					end
				end
				bcs_pkg::ADV_MOVE: begin
					if (!busy_s) begin
						adv_state <= bcs_pkg::ADV_IDLE;
						o_pump_on <= 1'b1;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// minute tick and beta counting
	logic [`BCS_TICK_W-1:0] tick_cnt;
	logic minute_tick;
	logic stage1;
	logic [`BCS_CNT_W-1:0] minute_cnt;

	assign minute_tick = tick_cnt == P_MINUTE_CYCLES - `BCS_TICK_W'(1);

	// timer restarts with the tape so minute one begins at the restart
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tick_cnt <= '0;
			stage1 <= 1'b0;
		end else begin
			stage1 <= minute_tick && !restart;
			if (restart || minute_tick) begin
				tick_cnt <= '0;
			end else begin
				tick_cnt <= tick_cnt + `BCS_TICK_W'(1);
			end
		end
	end

	// pulses are counted in every state, including tape motion
	// a pulse on the restart edge opens minute one, so that pulse is not lost
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			minute_cnt <= '0;
		end else if (restart) begin
			minute_cnt <= `BCS_CNT_W'(beta_edge);
		end else if (minute_tick) begin
			minute_cnt <= `BCS_CNT_W'(beta_edge);
		end else if (beta_edge && minute_cnt != '1) begin
			minute_cnt <= minute_cnt + `BCS_CNT_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// minute total history, newest at index zero
	logic [`BCS_CNT_W-1:0] hist [0:`BCS_HIST_DEPTH-1];
	logic [7:0] tape_min;
	logic [6:0] hour_min;

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			hist[0] <= '0;
		end else if (restart) begin
			hist[0] <= '0;
		end else if (minute_tick) begin
			hist[0] <= minute_cnt;
		end
	end

	generate
		for (gi = 1; gi < `BCS_HIST_DEPTH; gi++) begin : g_hist
			always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
				if (!i_arst_n) begin
					hist[gi] <= '0;
				end else if (restart) begin
					hist[gi] <= '0;
				end else if (minute_tick) begin
					hist[gi] <= hist[gi-1];
				end
			end
		end
	endgenerate

	// minute numbers since restart and within the hour
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tape_min <= 8'h0;
			hour_min <= 7'h0;
		end else begin
			if (restart) begin
				tape_min <= 8'h0;
			end else if (minute_tick && tape_min != `BCS_TAPE_MIN_MAX) begin
				tape_min <= tape_min + 8'h1;
			end
			if (minute_tick && !restart) begin
				hour_min <= (hour_min == `BCS_HOUR_MIN) ? 7'h1 : hour_min + 7'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// window sums and corrected raw value
	function automatic logic [`BCS_SUM_W-1:0] sum4(input logic [`BCS_CNT_W-1:0] a,
		input logic [`BCS_CNT_W-1:0] b, input logic [`BCS_CNT_W-1:0] c,
		input logic [`BCS_CNT_W-1:0] d);
		sum4 = `BCS_SUM_W'(a) + `BCS_SUM_W'(b) + `BCS_SUM_W'(c) + `BCS_SUM_W'(d);
	endfunction

	function automatic logic signed [22:0] sdiff(input logic [`BCS_SUM_W-1:0] a,
		input logic [`BCS_SUM_W-1:0] b);
		sdiff = $signed({1'b0, a}) - $signed({1'b0, b});
	endfunction

	logic [`BCS_SUM_W-1:0] final_sum;
	logic [`BCS_SUM_W-1:0] zero_hist;
	logic [`BCS_SUM_W-1:0] zero_fixed;
	logic [`BCS_SUM_W-1:0] zero_used;
	logic signed [22:0] raw_diff;
	logic [31:0] corr_mult;
	logic [15:0] corr_q;
	logic signed [39:0] raw_prod;
	logic signed [`BCS_RAW_W-1:0] raw_now;
	logic raw_ok;

	assign final_sum = sum4(hist[0], hist[1], hist[2], hist[3]);
	assign zero_hist = sum4(hist[8], hist[9], hist[10], hist[11]);
	// zero stays on minutes 1-4 until the lagging window catches up
	assign zero_used = (tape_min < `BCS_NORMAL_MIN) ? zero_fixed : zero_hist;
	assign raw_ok = tape_min >= `BCS_FIRST_RAW_MIN;
	assign raw_diff = sdiff(final_sum, zero_used);
	assign corr_mult = 32'(i_air_corr) * 32'(i_temp_corr);
	assign corr_q = corr_mult[`BCS_CORR_FRAC+15:`BCS_CORR_FRAC];
	assign raw_prod = 40'(raw_diff) * 40'($signed({1'b0, corr_q}));
	assign raw_now = raw_prod[`BCS_RAW_W+`BCS_CORR_FRAC-1:`BCS_CORR_FRAC];

	// zero window capture at the end of minute four
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			zero_fixed <= '0;
		end else if (restart) begin
			zero_fixed <= '0;
		end else if (stage1 && tape_min == `BCS_ZERO_LOAD_MIN) begin
			zero_fixed <= final_sum;
		end
	end

	// raw value and window outputs once per minute
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_raw_valid <= 1'b0;
			o_raw_prelim <= 1'b0;
			o_raw_conc <= '0;
			o_minute_total <= '0;
			o_final_window_average <= '0;
		end else begin
			o_raw_valid <= stage1 && raw_ok;
			if (stage1) begin
				o_minute_total <= hist[0];
				o_final_window_average <= final_sum[`BCS_SUM_W-1:2];
			end
			if (stage1 && raw_ok) begin
				o_raw_conc <= raw_now;
				o_raw_prelim <= tape_min < `BCS_NORMAL_MIN;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// real-time average over the selected period
	function automatic logic rt_boundary(input bcs_pkg::bcs_rt_period_type p,
		input logic [6:0] m);
		unique case (p)
			bcs_pkg::RT_5MIN: rt_boundary = (m % `BCS_RT_P5) == 7'h0;
			bcs_pkg::RT_10MIN: rt_boundary = (m % `BCS_RT_P10) == 7'h0;
			bcs_pkg::RT_15MIN: rt_boundary = (m % `BCS_RT_P15) == 7'h0;
			bcs_pkg::RT_30MIN: rt_boundary = (m % `BCS_RT_P30) == 7'h0;
			bcs_pkg::RT_60MIN: rt_boundary = (m % `BCS_RT_P60) == 7'h0;
			default: rt_boundary = (m % `BCS_RT_P1) == 7'h0;
		endcase
	endfunction

	logic signed [31:0] rt_acc;
	logic [7:0] rt_n;
	logic rt_start;
	logic rt_done;
	logic signed [31:0] rt_quot;

	assign rt_start = stage1 && rt_boundary(i_rt_period, hour_min) && rt_n != 8'h0;

	// this minute's raw value opens the next period
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rt_acc <= 32'h0;
			rt_n <= 8'h0;
		end else if (stage1 && rt_boundary(i_rt_period, hour_min)) begin
			rt_acc <= raw_ok ? 32'(raw_now) : 32'h0;
			rt_n <= raw_ok ? 8'h1 : 8'h0;
		end else if (stage1 && raw_ok) begin
			rt_acc <= rt_acc + 32'(raw_now);
			rt_n <= rt_n + 8'h1;
		end
	end

	bcs_divider u_rt_div (
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.i_start(rt_start),
		.i_dividend(rt_acc),
		.i_divisor(rt_n),
		.o_busy(),
		.o_done(rt_done),
		.o_quot(rt_quot)
	);

	// result held until the next boundary
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rt_valid <= 1'b0;
			o_rt_avg <= 32'h0;
		end else begin
			o_rt_valid <= rt_done;
			if (rt_done) begin
				o_rt_avg <= rt_quot;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// hourly zero, span and split-cycle weighting
	logic [`BCS_SUM_W-1:0] hour_zero;
	logic [`BCS_SUM_W-1:0] span_acc;
	logic [`BCS_SUM_W-1:0] span_full;
	logic signed [31:0] seg_acc;
	logic [6:0] seg_start;
	logic split;
	logic pd_flag;
	logic hour_end;
	logic signed [22:0] diff_last;
	logic signed [22:0] diff_seg;
	logic signed [31:0] hour_num;
	logic signed [31:0] seg_term;
	logic hour_done;
	logic signed [31:0] hour_quot;

	assign hour_end = stage1 && hour_min == `BCS_HOUR_MIN;
	assign span_full = span_acc + `BCS_SUM_W'(hist[0]);
	assign diff_last = sdiff(span_full, split ? zero_fixed : hour_zero);
	assign hour_num = seg_acc + 32'(diff_last) * 32'(`BCS_HOUR_MIN - seg_start);
	assign diff_seg = sdiff(final_sum, split ? zero_fixed : hour_zero);
	assign seg_term = 32'(diff_seg) * 32'(hour_min - seg_start);

	// zero and span accumulation on the hour's minute numbers
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			hour_zero <= '0;
			span_acc <= '0;
		end else if (stage1) begin
			if (hour_min == `BCS_ZERO_FIRST) begin
				hour_zero <= `BCS_SUM_W'(hist[0]);
			end else if (hour_min > `BCS_ZERO_FIRST && hour_min <= `BCS_ZERO_LAST) begin
				hour_zero <= hour_zero + `BCS_SUM_W'(hist[0]);
			end
			if (hour_min == `BCS_SPAN_FIRST) begin
				span_acc <= `BCS_SUM_W'(hist[0]);
			end else if (hour_min > `BCS_SPAN_FIRST && hour_min < `BCS_SPAN_LAST) begin
				span_acc <= span_acc + `BCS_SUM_W'(hist[0]);
			end
		end
	end

	// segments closed by tape advances, weighted by their minutes
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			seg_acc <= 32'h0;
			seg_start <= 7'h0;
			split <= 1'b0;
			pd_flag <= 1'b0;
		end else if (restart) begin
			seg_acc <= seg_acc + seg_term;
			seg_start <= (hour_min == `BCS_HOUR_MIN) ? 7'h0 : hour_min;
			split <= 1'b1;
			pd_flag <= pd_flag || clog_pending;
		end else if (hour_end) begin
			seg_acc <= 32'h0;
			seg_start <= 7'h0;
			split <= 1'b0;
			pd_flag <= 1'b0;
		end
	end

	bcs_divider u_hour_div (
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.i_start(hour_end),
		.i_dividend(hour_num),
		.i_divisor(`BCS_HOUR_DIV),
		.o_busy(),
		.o_done(hour_done),
		.o_quot(hour_quot)
	);

	// store the finished hour, flags captured at the boundary
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_hour_valid <= 1'b0;
			o_hour_conc <= 32'h0;
			o_hour_split <= 1'b0;
			o_hour_pd_alarm <= 1'b0;
		end else begin
			o_hour_valid <= hour_done;
			if (hour_end) begin
				o_hour_split <= split;
				o_hour_pd_alarm <= pd_flag;
			end
			if (hour_done) begin
				o_hour_conc <= hour_quot;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// daily mean of 24 hourly values
	logic signed [31:0] day_acc;
	logic [4:0] day_n;
	logic day_start;
	logic day_done;
	logic signed [31:0] day_quot;

	assign day_start = hour_done && day_n == `BCS_DAY_HOURS - 5'd1;

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			day_acc <= 32'h0;
			day_n <= 5'h0;
		end else if (day_start) begin
			day_acc <= 32'h0;
			day_n <= 5'h0;
		end else if (hour_done) begin
			day_acc <= day_acc + hour_quot;
			day_n <= day_n + 5'h1;
		end
	end

	bcs_divider u_day_div (
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.i_start(day_start),
		.i_dividend(day_acc + hour_quot),
		.i_divisor(`BCS_DAY_DIV),
		.o_busy(),
		.o_done(day_done),
		.o_quot(day_quot)
	);

	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_day_valid <= 1'b0;
			o_day_avg <= 32'h0;
		end else begin
			o_day_valid <= day_done;
			if (day_done) begin
				o_day_avg <= day_quot;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_move_end;
		adv_state == bcs_pkg::ADV_MOVE && !busy_s;
	endsequence

	sequence s_hour_close;
		stage1 && hour_min == `BCS_HOUR_MIN;
	endsequence

	a_restart_clears: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		s_move_end |=> tape_min == 8'h0 && zero_fixed == '0 &&
		minute_cnt == `BCS_CNT_W'($past(beta_edge)))
		else $error("restart did not clear counts");

	a_no_early_raw: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		o_raw_valid |-> tape_min >= `BCS_FIRST_RAW_MIN)
		else $error("raw value before minute five");

	a_raw_each_min: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		stage1 && tape_min >= `BCS_FIRST_RAW_MIN |=> o_raw_valid)
		else $error("raw value missing for minute");

	a_prelim_flag: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		o_raw_valid |-> o_raw_prelim == (tape_min < `BCS_NORMAL_MIN))
		else $error("preliminary flag wrong");

	a_hour_stored: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		s_hour_close |-> ##[34:36] o_hour_valid)
		else $error("hourly value not stored");

	a_rt_hold: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		!o_rt_valid |-> $stable(o_rt_avg))
		else $error("real-time average changed between boundaries");

	a_clog_forced: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		adv_state == bcs_pkg::ADV_IDLE && clog_rise |=> o_clog_alarm && o_tape_advance)
		else $error("clog did not force advance");

	a_pump_moving: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		adv_state == bcs_pkg::ADV_MOVE ##1 adv_state == bcs_pkg::ADV_MOVE |-> !o_pump_on)
		else $error("pump running during tape move");

	a_pump_idle: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
		adv_state == bcs_pkg::ADV_IDLE [*2] |-> o_pump_on)
		else $error("pump stopped outside tape move");

endmodule // bcs_sequencer

`default_nettype wire

// ---- verif/bcs_beta_source.sv ----
// Purpose: detector pulse source and tape transport model
// Assumes: pulse period divides the minute length
// Notes: busy rises a few cycles after a request and falls after P_MOVE
`timescale 1ns/100ps
`default_nettype none

module bcs_beta_source #(
	parameter int P_PER = 8,
	parameter int P_MOVE = 40
) (
	input wire logic i_clk_sys, // system clock
	input wire logic i_arst_n, // reset, active low
	input wire logic i_tape_advance, // advance request
	output logic o_beta_pulse, // detector pulse
	output logic o_tape_busy // transport moving
);
	int ph;
	int mv;
	////////////////////////////////////////////////
	// steady pulse train, two cycles high per period
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ph <= 0;
		end else begin
			ph <= (ph == P_PER - 1) ? 0 : ph + 1;
		end
	end
	assign o_beta_pulse = (ph < 2);
	// transport runs a fixed move once a request is seen
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			mv <= 0;
		end else if (mv != 0) begin
			mv <= (mv == P_MOVE) ? 0 : mv + 1;
		end else if (i_tape_advance) begin
			mv <= 1;
		end
	end
	assign o_tape_busy = (mv > 2);
endmodule // bcs_beta_source

`default_nettype wire

// ---- verif/tb.sv ----
// Purpose: self-checking bench for the beta count sequencer
// Assumes: minute shortened to 200 cycles
// Notes: a steady pulse rate keeps windows flat, so differences are zero
`timescale 1ns/100ps
`default_nettype none

module tb;
	localparam int MIN = 200;
	logic i_clk_sys = 1'b0;
	logic i_arst_n = 1'b0;
	logic i_tape_clog = 1'b0;
	logic i_advance_due = 1'b0;
	bcs_pkg::bcs_rt_period_type i_rt_period = bcs_pkg::RT_1MIN;
	logic beta, busy, adv, pump, clog_alarm, raw_valid, raw_prelim, rt_valid, hour_valid;
	logic split, pd_alarm;
	logic [19:0] min_total, fwa;
	logic signed [23:0] raw_conc;
	logic signed [31:0] rt_avg, hour_conc;
	logic [5:0] ev;
	int errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int per[6] = '{1, 5, 10, 15, 30, 60};
	assign ev = {pump, ~pump, clog_alarm, hour_valid, rt_valid, raw_valid};
	always #2.5 i_clk_sys = ~i_clk_sys;
	////////////////////////////////////////////////
	bcs_sequencer #(.P_MINUTE_CYCLES(34'h0C8)) i_bcs_sequencer (.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n), .i_beta_pulse(beta), .i_tape_clog(i_tape_clog),
		.i_tape_busy(busy), .i_advance_due(i_advance_due), .i_rt_period(i_rt_period),
		.i_air_corr(16'h0100), .i_temp_corr(16'h0100), .o_tape_advance(adv),
		.o_pump_on(pump), .o_clog_alarm(clog_alarm), .o_minute_total(min_total),
		.o_final_window_average(fwa), .o_raw_valid(raw_valid), .o_raw_prelim(raw_prelim),
		.o_raw_conc(raw_conc), .o_rt_valid(rt_valid), .o_rt_avg(rt_avg),
		.o_hour_valid(hour_valid), .o_hour_conc(hour_conc), .o_hour_split(split),
		.o_hour_pd_alarm(pd_alarm), .o_day_valid(), .o_day_avg());
	bcs_beta_source i_bcs_beta_source (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
		.i_tape_advance(adv), .o_beta_pulse(beta), .o_tape_busy(busy));
	////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge i_clk_sys);
		#1;
	endtask
	// bounded wait on one event bit
	task automatic wait_on(input int sel, input int lim, output int n);
		n = 0;
		do begin
			step(1);
			n++;
		end while (ev[sel] !== 1'b1 && n < lim);
		check(32'(n < lim), 32'h1);
	endtask
	// raw values from tape minute 5 to 13
	task automatic t_raw_seq;
		int n;
		wait_on(0, 1100, n);
		check(32'(n > 4 * MIN), 32'h1);
		for (int m = 5; m <= 13; m++) begin
			if (m > 5) begin
				wait_on(0, MIN + 5, n);
				check(32'(n), 32'(MIN));
			end
			check(32'(raw_prelim), 32'(m < 12));
			check(32'(min_total), 32'h19);
			check(32'(fwa), 32'h19);
			check(32'(raw_conc), 32'h0);
		end
	endtask
	// every averaging period, held between boundaries
	task automatic t_rt;
		int n;
		for (int p = 0; p < 6; p++) begin
			i_rt_period = bcs_pkg::bcs_rt_period_type'(p);
			wait_on(1, 62 * MIN, n);
			wait_on(1, 62 * MIN, n);
			check(32'(n <= per[p] * MIN), 32'h1);
			check(rt_avg, 32'h0);
			step(MIN / 2);
			check(rt_avg, 32'h0);
		end
	endtask
	task automatic t_hour(input logic pd);
		int n;
		wait_on(2, 61 * MIN, n);
		check(32'(pd_alarm), 32'(pd));
		check(32'(split), 32'(pd));
		if (!pd) check(hour_conc, 32'h0);
	endtask
	// periodic advance, then clog-forced advance
	task automatic t_adv;
		int n;
		i_advance_due = 1'b1;
		step(1);
		i_advance_due = 1'b0;
		step(1);
		check(32'(adv), 32'h1);
		wait_on(4, 20, n);
		check(32'(pump), 32'h0);
		wait_on(5, 100, n);
		t_raw_seq;
		i_tape_clog = 1'b1;
		wait_on(3, 10, n);
		check(32'(clog_alarm), 32'h1);
		i_tape_clog = 1'b0;
		wait_on(4, 20, n);
		check(32'(pump), 32'h0);
		wait_on(5, 100, n);
		check(32'(pump), 32'h1);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	////////////////////////////////////////////////
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 90000) begin
			errors++;
			complete_run;
		end
	end
	initial begin
		step(20);
		check(32'(pump), 32'h1); // reset value
		i_arst_n = 1'b1;
		t_raw_seq;
		t_rt;
		t_hour(1'b0);
		t_adv;
		t_hour(1'b1);
		complete_run;
	end
endmodule // tb

`default_nettype wire
